// ==== hw/tsc_top.sv ====
// Timer section control: shared start/stop register for three timers and timer zero.
// Assumes tick strobes and event pulses are one-cycle pulses on clk_i; the
// low-frequency oscillator input is asynchronous and is synchronised here.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
module tsc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Tick sources
    input wire logic tick_fast_i,
    input wire logic tick_slow_i,
    input wire logic timer1_underflow_i,
    input wire logic timer2_underflow_i,
    // Link events
    input wire logic tx_end_i,
    input wire logic rx_first_bits_i,
    input wire logic low_frequency_oscillator_i,
    // Other timers
    input wire logic [3:1] timer_ext_stop_i,
    output logic [3:0] timer_active_o,
    output logic timer0_underflow_o,
    // Interrupt
    output logic irq_o
);
    import tsc_pkg::*;

    // ------------------------------------------------------------
    // Wishbone access
    // ------------------------------------------------------------
    logic ack_r;
    logic [31:0] rdat_r;
    logic [7:0] rd_nxt;
    logic bus_req;
    logic wr_fire;
    logic [5:0] idx;
    logic [7:0] wdat;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_rld;

    assign bus_req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[7:2];
    assign wdat = wb_dat_i[7:0];
    // A write takes effect on the edge at which the master samples ack.
    assign wr_fire = bus_req & ack_r & wb_we_i & wb_sel_i[0];
    assign wr_ctrl = wr_fire && (idx == IDX_CTRL);
    assign wr_cfg = wr_fire && (idx == IDX_CFG);
    assign wr_rld = wr_fire && ((idx == IDX_RLD_HI) || (idx == IDX_RLD_LO));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    // ------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] rld_hi_r;
    logic [7:0] rld_lo_r;
    logic [15:0] count_r;
    logic [3:0] active_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] en_r;
    logic irq_r;
    logic uf_r;
    logic [15:0] reload;
    logic [1:0] mode;
    logic lfo_mode;
    logic restart;

    assign reload = {rld_hi_r, rld_lo_r};
    assign mode = cfg_r[CFG_MODE_LSB +: 2];
    assign lfo_mode = mode[1];
    assign restart = cfg_r[CFG_RESTART_BIT];

    // Counter bytes are sampled live; during reception they may be mid-update.
    always_comb begin
        rd_nxt = RST_BYTE;
        case (idx)
            IDX_CTRL: rd_nxt = {active_r, 4'h0};
            IDX_CFG: rd_nxt = cfg_r & CFG_MASK;
            IDX_RLD_HI: rd_nxt = rld_hi_r;
            IDX_RLD_LO: rd_nxt = rld_lo_r;
            IDX_CNT_HI: rd_nxt = count_r[15:8];
            IDX_CNT_LO: rd_nxt = count_r[7:0];
            IDX_IRQ_STAT: rd_nxt = {6'h00, stat_r};
            IDX_IRQ_EN: rd_nxt = {6'h00, en_r};
            default: rd_nxt = RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0000_0000;
        end else if (bus_req & ~ack_r) begin
            rdat_r <= {24'h00_0000, rd_nxt};
        end
    end

    // ------------------------------------------------------------
    // Oscillator edge synchroniser
    // ------------------------------------------------------------
    logic lfo_meta_r;
    logic lfo_sync_r;
    logic lfo_prev_r;
    logic lfo_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfo_meta_r <= 1'b0;
            lfo_sync_r <= 1'b0;
            lfo_prev_r <= 1'b0;
        end else begin
            lfo_meta_r <= low_frequency_oscillator_i;
            lfo_sync_r <= lfo_meta_r;
            lfo_prev_r <= lfo_sync_r;
        end
    end

    assign lfo_rise = lfo_sync_r & ~lfo_prev_r;

    // ------------------------------------------------------------
    // Timer zero events
    // ------------------------------------------------------------
    logic sw_start0;
    logic sw_stop0;
    logic auto_start;
    logic lfo_start;
    logic lfo_stop;
    logic rx_halt;
    logic start0;
    logic tick_sel;
    logic tick0;
    logic at_zero;
    logic underflow;
    logic stop0;

    assign sw_start0 = wr_ctrl & wdat[0] & wdat[CTRL_FLAG_LSB];
    assign sw_stop0 = wr_ctrl & wdat[0] & ~wdat[CTRL_FLAG_LSB];
    assign auto_start = (mode == MODE_TX_END) & tx_end_i;
    // Each rising oscillator edge toggles the measurement.
    assign lfo_start = lfo_mode & lfo_rise & ~active_r[0];
    assign lfo_stop = lfo_mode & lfo_rise & active_r[0];
    assign rx_halt = cfg_r[CFG_HALT_RX_BIT] & ~lfo_mode & rx_first_bits_i;
    assign start0 = sw_start0 | auto_start | lfo_start;

    always_comb begin
        tick_sel = 1'b0;
        case (cfg_r[CFG_TICK_LSB +: 2])
            TICK_FAST: tick_sel = tick_fast_i;
            TICK_SLOW: tick_sel = tick_slow_i;
            TICK_T2: tick_sel = timer2_underflow_i;
            TICK_T1: tick_sel = timer1_underflow_i;
            default: tick_sel = 1'b0;
        endcase
    end

    assign tick0 = active_r[0] & tick_sel;
    assign at_zero = (count_r == RST_COUNT);
    // Trimming without underflow parks at zero until the closing edge.
    assign underflow = tick0 & at_zero & (mode != MODE_LFO_NOUF) & ~start0;
    assign stop0 = ~start0 & active_r[0]
        & (sw_stop0 | lfo_stop | rx_halt | (underflow & ~restart));

    // ------------------------------------------------------------
    // Configuration and reload registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= RST_BYTE;
        end else if (wr_cfg) begin
            cfg_r <= wdat & CFG_MASK;
        end
    end

    // Reload bytes only feed the counter at a start or restart.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rld_hi_r <= RST_BYTE;
            rld_lo_r <= RST_BYTE;
        end else if (wr_rld) begin
            if (idx == IDX_RLD_HI) begin
                rld_hi_r <= wdat;
            end else begin
                rld_lo_r <= wdat;
            end
        end
    end

    // ------------------------------------------------------------
    // Timer zero counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= RST_COUNT;
        end else if (start0) begin
            count_r <= reload;
        end else if (underflow & restart) begin
            count_r <= reload;
        end else if (tick0 & ~at_zero) begin
            count_r <= count_r - 16'h0001;
        end
    end

    // A start in the same cycle as any stop wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_r[0] <= 1'b0;
        end else if (start0) begin
            active_r[0] <= 1'b1;
        end else if (stop0) begin
            active_r[0] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Running flags of timers one to three
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 1; gi < 4; gi = gi + 1) begin : g_flag
            logic set_w;
            logic clr_w;
            assign set_w = wr_ctrl & wdat[gi] & wdat[gi + CTRL_FLAG_LSB];
            assign clr_w = (wr_ctrl & wdat[gi] & ~wdat[gi + CTRL_FLAG_LSB])
                | timer_ext_stop_i[gi];
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    active_r[gi] <= 1'b0;
                end else if (set_w) begin
                    active_r[gi] <= 1'b1;
                end else if (clr_w) begin
                    active_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr_mask;

    assign ev = {stop0, underflow};
    assign clr_mask = (wr_fire && (idx == IDX_IRQ_CLR)) ? wdat[IRQ_W-1:0] : RST_IRQ;

    // A new event in the clearing cycle stays set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= RST_IRQ;
        end else begin
            stat_r <= (stat_r & ~clr_mask) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= RST_IRQ;
        end else if (wr_fire && (idx == IDX_IRQ_EN)) begin
            en_r <= wdat[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
            uf_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & en_r);
            uf_r <= underflow;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign timer_active_o = active_r;
    assign timer0_underflow_o = uf_r;
    assign irq_o = irq_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_mask_keeps_flag: assert property (
        wr_ctrl & ~wdat[3] & ~timer_ext_stop_i[3] |=> active_r[3] == $past(active_r[3]))
        else $error("masked control write changed timer three flag");
    chk_start_sets_flag: assert property (
        wr_ctrl & wdat[1] & wdat[5]
        |=> active_r[1] ##1 (timer_active_o[1] | $past(timer_ext_stop_i[1])))
        else $error("enabled start did not raise timer one flag");
    chk_rx_halt_stops: assert property (
        rx_halt & active_r[0] & ~start0 |=> ~active_r[0])
        else $error("halt on receive did not stop timer zero");
    chk_lfo_ignores_rx: assert property (
        lfo_mode & rx_first_bits_i & active_r[0] & ~lfo_rise & ~underflow & ~sw_stop0
        |=> active_r[0])
        else $error("trimming mode stopped on receive");
    chk_mode0_no_auto: assert property (
        (mode == MODE_NONE) & ~active_r[0] & ~sw_start0 |=> ~active_r[0])
        else $error("timer zero started by itself in mode zero");
    chk_tx_end_load: assert property (
        (mode == MODE_TX_END) & tx_end_i |=> active_r[0] && count_r == $past(reload))
        else $error("transmission end did not start and load timer zero");
    chk_lfo_start: assert property (
        lfo_mode & lfo_rise & ~active_r[0] |=> active_r[0])
        else $error("oscillator edge did not start measurement");
    chk_restart_reload: assert property (
        underflow & restart & ~stop0 |=> active_r[0] && count_r == $past(reload))
        else $error("auto restart did not reload");
    chk_zero_stop: assert property (
        underflow & ~restart |=> ~active_r[0] ##1 (~timer_active_o[0] | $past(start0)))
        else $error("timer zero kept running after zero");
    chk_uf_irq_flag: assert property (
        underflow |=> stat_r[IRQ_UNDERFLOW] ##1 (irq_o | ~$past(en_r[IRQ_UNDERFLOW])))
        else $error("underflow did not set interrupt flag");
    chk_tick_t1_count: assert property (
        (cfg_r[1:0] == TICK_T1) & active_r[0] & timer1_underflow_i & ~at_zero & ~start0
        |=> count_r == $past(count_r) - 16'h0001)
        else $error("timer one underflow did not advance timer zero");
    chk_reload_holds: assert property (
        wr_rld & ~start0 & ~tick0 |=> count_r == $past(count_r))
        else $error("reload write disturbed running count");
    chk_decrement_one: assert property (
        tick0 & ~at_zero & ~start0 |=> count_r == $past(count_r) - 16'h0001)
        else $error("counter did not decrement by one");
    chk_wb_ack: assert property (
        bus_req & ~ack_r |=> wb_ack_o)
        else $error("bus request not acknowledged");

    cov_tx_start: cover property ((mode == MODE_TX_END) & tx_end_i ##1 active_r[0]);
    cov_restart: cover property (underflow & restart);
    cov_lfo_measure: cover property (lfo_start ##[1:1000] lfo_stop);
    cov_irq: cover property (~irq_o ##1 irq_o);

endmodule

// ==== hw/tsc_pkg.sv ====
// Constants for the timer section control block.
// Assumes a Wishbone slave with 32-bit data and byte addresses four times the index.
package tsc_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL = 6'h0E;
    localparam logic [5:0] IDX_CFG = 6'h0F;
    localparam logic [5:0] IDX_RLD_HI = 6'h10;
    localparam logic [5:0] IDX_RLD_LO = 6'h11;
    localparam logic [5:0] IDX_CNT_HI = 6'h12;
    localparam logic [5:0] IDX_CNT_LO = 6'h13;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h21;
    localparam logic [5:0] IDX_IRQ_EN = 6'h22;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_FLAG_LSB = 4;
    localparam int CFG_HALT_RX_BIT = 7;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_RESTART_BIT = 3;
    localparam int CFG_TICK_LSB = 0;
    localparam logic [7:0] CFG_MASK = 8'hBB;
    localparam int IRQ_UNDERFLOW = 0;
    localparam int IRQ_STOPPED = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------
    // Modes and tick sources
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_TX_END = 2'h1;
    localparam logic [1:0] MODE_LFO_NOUF = 2'h2;
    localparam logic [1:0] MODE_LFO_UF = 2'h3;
    localparam logic [1:0] TICK_FAST = 2'h0;
    localparam logic [1:0] TICK_SLOW = 2'h1;
    localparam logic [1:0] TICK_T2 = 2'h2;
    localparam logic [1:0] TICK_T1 = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [1:0] RST_IRQ = 2'h0;

endpackage

// ==== verification/tb_top.sv ====
// Self-checking testbench for the timer section control block.
// Assumes the block answers Wishbone requests with a registered ack and that
// event inputs are one-cycle pulses on the system clock.
`timescale 1ns/10ps
module tb_top;
    import tsc_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [8:0] pulse_v = 9'h000;
    logic lfo_v = 1'b0;
    logic [3:0] timer_active_o;
    logic timer0_underflow_o;
    logic irq_o;
    logic uf_seen = 1'b0;
    int errors = 0;
    int samples_checked = 0;

    always #4 clk_i = ~clk_i;

    // Pulse vector bits: fast, slow, timer1 and timer2 underflow, tx end, rx bits, ext stops.
    tsc_top DUT (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tick_fast_i(pulse_v[0]), .tick_slow_i(pulse_v[1]),
        .timer1_underflow_i(pulse_v[2]), .timer2_underflow_i(pulse_v[3]),
        .tx_end_i(pulse_v[4]), .rx_first_bits_i(pulse_v[5]),
        .low_frequency_oscillator_i(lfo_v), .timer_ext_stop_i(pulse_v[8:6]),
        .timer_active_o(timer_active_o), .timer0_underflow_o(timer0_underflow_o), .irq_o(irq_o)
    );

    // The underflow output is a single-cycle pulse, so it is caught here.
    always @(posedge clk_i) begin
        if (timer0_underflow_o === 1'b1) begin
            uf_seen <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [5:0] idx, input logic [7:0] wdat,
                            output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h00_0000, wdat};
        // Only the acknowledge or the watchdog ends this wait.
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        wb_cycle(1'b1, idx, d, unused);
    endtask

    task automatic rd_chk(input string what, input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] got;
        wb_cycle(1'b0, idx, 8'h00, got);
        chk(what, {24'h00_0000, exp}, got);
    endtask

    task automatic pulse(input logic [8:0] m, input int k);
        repeat (k) begin
            @(posedge clk_i);
            pulse_v <= m;
            @(posedge clk_i);
            pulse_v <= 9'h000;
        end
    endtask

    task automatic lfo_rise();
        @(posedge clk_i);
        lfo_v <= 1'b1;
        repeat (6) @(posedge clk_i);
        lfo_v <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic act_chk(input logic [3:0] exp);
        repeat (3) @(posedge clk_i);
        chk("timer_active_o", {28'h000_0000, exp}, {28'h000_0000, timer_active_o});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk("ctrl", IDX_CTRL, 8'h00);
        rd_chk("count_hi", IDX_CNT_HI, 8'h00);
        rd_chk("count_lo", IDX_CNT_LO, 8'h00);
        wr(IDX_CFG, 8'hFF);
        rd_chk("cfg", IDX_CFG, CFG_MASK);
        wr(IDX_RLD_HI, 8'hA5);
        wr(IDX_RLD_LO, 8'h5A);
        rd_chk("reload_hi", IDX_RLD_HI, 8'hA5);
        rd_chk("reload_lo", IDX_RLD_LO, 8'h5A);
        wr(IDX_CNT_LO, 8'h77);
        rd_chk("count_lo", IDX_CNT_LO, 8'h00);
        wr(6'h3F, 8'hFF);
        rd_chk("unmapped", 6'h3F, 8'h00);
        wr(IDX_CFG, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_ctrl();
        wr(IDX_CTRL, 8'hF0);
        rd_chk("ctrl", IDX_CTRL, 8'h00);
        wr(IDX_CTRL, 8'hFF);
        rd_chk("ctrl", IDX_CTRL, 8'hF0);
        act_chk(4'hF);
        pulse(9'h080, 1);
        rd_chk("ctrl", IDX_CTRL, 8'hB0);
        wr(IDX_CTRL, 8'h0E);
        rd_chk("ctrl", IDX_CTRL, 8'h10);
        wr(IDX_CTRL, 8'h01);
        rd_chk("ctrl", IDX_CTRL, 8'h00);
        act_chk(4'h0);
        $display("test ctrl done");
    endtask

    task automatic t_count();
        wr(IDX_RLD_HI, 8'h01);
        wr(IDX_RLD_LO, 8'h02);
        wr(IDX_CTRL, 8'h11);
        // Counter bytes are only read while no reception is in progress.
        rd_chk("count_hi", IDX_CNT_HI, 8'h01);
        rd_chk("count_lo", IDX_CNT_LO, 8'h02);
        pulse(9'h001, 3);
        rd_chk("count_hi", IDX_CNT_HI, 8'h00);
        rd_chk("count_lo", IDX_CNT_LO, 8'hFF);
        wr(IDX_RLD_HI, 8'h00);
        wr(IDX_RLD_LO, 8'h05);
        pulse(9'h002, 1);
        rd_chk("count_lo", IDX_CNT_LO, 8'hFF);
        wr(IDX_CTRL, 8'h11);
        rd_chk("count_lo", IDX_CNT_LO, 8'h05);
        wr(IDX_CTRL, 8'h01);
        $display("test count done");
    endtask

    task automatic t_underflow();
        wr(IDX_IRQ_CLR, 8'h03);
        wr(IDX_IRQ_EN, 8'h01);
        wr(IDX_RLD_LO, 8'h02);
        wr(IDX_CTRL, 8'h11);
        pulse(9'h001, 2);
        act_chk(4'h1);
        rd_chk("count_lo", IDX_CNT_LO, 8'h00);
        chk("irq_o", 32'h0000_0000, {31'h0, irq_o});
        pulse(9'h001, 1);
        act_chk(4'h0);
        rd_chk("irq_status", IDX_IRQ_STAT, 8'h03);
        chk("irq_o", 32'h0000_0001, {31'h0, irq_o});
        wr(IDX_IRQ_EN, 8'h00);
        act_chk(4'h0);
        chk("irq_o", 32'h0000_0000, {31'h0, irq_o});
        wr(IDX_IRQ_EN, 8'h01);
        act_chk(4'h0);
        chk("irq_o", 32'h0000_0001, {31'h0, irq_o});
        wr(IDX_IRQ_CLR, 8'h03);
        rd_chk("irq_status", IDX_IRQ_STAT, 8'h00);
        chk("irq_o", 32'h0000_0000, {31'h0, irq_o});
        wr(IDX_CFG, 8'h08);
        wr(IDX_CTRL, 8'h11);
        pulse(9'h001, 3);
        act_chk(4'h1);
        rd_chk("count_lo", IDX_CNT_LO, 8'h02);
        rd_chk("irq_status", IDX_IRQ_STAT, 8'h01);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_CFG, 8'h00);
        wr(IDX_IRQ_CLR, 8'h03);
        $display("test underflow done");
    endtask

    task automatic t_sources();
        int match [4] = '{0, 1, 3, 2};
        logic [7:0] exp;
        wr(IDX_RLD_LO, 8'h10);
        for (int s = 0; s < 4; s++) begin
            wr(IDX_CFG, 8'(s));
            wr(IDX_CTRL, 8'h11);
            exp = 8'h10;
            for (int b = 0; b < 4; b++) begin
                pulse(9'(1 << b), 1);
                if (b == match[s]) begin
                    exp = 8'h0F;
                end
                rd_chk("count_lo", IDX_CNT_LO, exp);
            end
        end
        wr(IDX_CTRL, 8'h01);
        $display("test sources done");
    endtask

    task automatic t_modes();
        wr(IDX_RLD_LO, 8'h04);
        wr(IDX_CFG, 8'h00);
        pulse(9'h010, 1);
        act_chk(4'h0);
        wr(IDX_CFG, 8'h10);
        pulse(9'h010, 1);
        act_chk(4'h1);
        rd_chk("count_lo", IDX_CNT_LO, 8'h04);
        wr(IDX_CFG, 8'h90);
        pulse(9'h020, 1);
        act_chk(4'h0);
        wr(IDX_CFG, 8'h10);
        wr(IDX_CTRL, 8'h11);
        pulse(9'h020, 1);
        act_chk(4'h1);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_RLD_LO, 8'h01);
        wr(IDX_CFG, 8'hA0);
        uf_seen <= 1'b0;
        lfo_rise();
        act_chk(4'h1);
        pulse(9'h020, 1);
        act_chk(4'h1);
        pulse(9'h001, 2);
        rd_chk("count_lo", IDX_CNT_LO, 8'h00);
        chk("underflow_pulse", 32'h0000_0000, {31'h0, uf_seen});
        lfo_rise();
        act_chk(4'h0);
        wr(IDX_CFG, 8'hB0);
        wr(IDX_IRQ_CLR, 8'h03);
        lfo_rise();
        pulse(9'h001, 2);
        rd_chk("irq_status", IDX_IRQ_STAT, 8'h03);
        chk("underflow_pulse", 32'h0000_0001, {31'h0, uf_seen});
        act_chk(4'h0);
        $display("test modes done");
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_ctrl();
        t_count();
        t_underflow();
        t_sources();
        t_modes();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        $display("Error watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule
